// file: hw/dual_timer_pkg.sv
// Register map, field positions and reset values of the dual timer block
package dual_timer_pkg;

	// Register indices; the APB byte address is four times the index
	localparam logic [15:0] IDX_PRIO     = 16'hff20;
	localparam logic [15:0] IDX_IRQ_EN   = 16'hff24;
	localparam logic [15:0] IDX_FLAGS    = 16'hff28;
	localparam logic [15:0] IDX_CTRL0    = 16'hff30;
	localparam logic [15:0] IDX_CTRL1    = 16'hff31;
	localparam logic [15:0] IDX_RELOAD0  = 16'hff32;
	localparam logic [15:0] IDX_RELOAD1  = 16'hff33;
	localparam logic [15:0] IDX_CMP0     = 16'hff34;
	localparam logic [15:0] IDX_CMP1     = 16'hff35;
	localparam logic [15:0] IDX_COUNT0   = 16'hff36;
	localparam logic [15:0] IDX_COUNT1   = 16'hff37;
	localparam logic [15:0] IDX_FLOAT    = 16'hffd4;
	localparam logic [15:0] IDX_PIN_DATA = 16'hffd9;

	// Priority register: two bits per timer
	localparam int PRIO_ZERO_LSB = 0;
	localparam int PRIO_ONE_LSB  = 2;

	// Enable and flag registers share bit positions
	localparam int BIT_UF_ZERO  = 3;
	localparam int BIT_CMP_ZERO = 4;
	localparam int BIT_UF_ONE   = 5;
	localparam int BIT_CMP_ONE  = 6;

	// Timer control registers
	localparam int BIT_PRESET  = 1;
	localparam int BIT_RUN     = 2;
	localparam int BIT_OUT_EN  = 3;
	localparam int BIT_COMBINE = 7;

	// Reset values
	localparam logic [7:0] RST_RELOAD = 8'hff;
	localparam logic [7:0] RST_CMP    = 8'h00;
	localparam logic [1:0] RST_FLOAT  = 2'h3;
	localparam logic [1:0] RST_DATA   = 2'h3;
	localparam logic [1:0] RST_PRIO   = 2'h0;

endpackage

// file: hw/timer_count_channel.sv
// One 8-bit down counter with reload and compare detection
`timescale 1ns/1ps
module timer_count_channel (
	input  wire logic       clk_sys,    // System clock
	input  wire logic       reset,      // Synchronous reset
	input  wire logic       tick,       // Count one step down
	input  wire logic       load,       // Load the reload value
	input  wire logic [7:0] reload_val, // Reload data
	input  wire logic [7:0] cmp_val,    // Compare data
	output logic      [7:0] count,      // Counter value
	output logic            zero,       // Counter is zero
	output logic            changed,    // Counter changes this cycle
	output logic            next_match  // Next value equals compare data
);
	typedef struct packed {
		logic [7:0] cnt;
	} chan_s;

	chan_s st_q;
	chan_s st_d;

	// Load beats count so a reload is never lost to a tick
	always_comb begin
		st_d = st_q;
		if (load) begin
			st_d.cnt = reload_val;
		end else if (tick) begin
			st_d.cnt = st_q.cnt - 8'h01;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			st_q <= '{cnt: dual_timer_pkg::RST_RELOAD};
		end else begin
			st_q <= st_d;
		end
	end

	assign count      = st_q.cnt;
	assign zero       = (st_q.cnt == 8'h00);
	assign changed    = load | tick;
	assign next_match = (st_d.cnt == cmp_val);
endmodule // timer_count_channel

// file: hw/timer_pin_driver.sv
// Output port pin stage: float, data gating and clock source selection
`timescale 1ns/1ps
module timer_pin_driver (
	input  wire logic clk_sys,   // System clock
	input  wire logic reset,     // Synchronous reset
	input  wire logic out_en,    // Timer clock output enable
	input  wire logic tclk,      // Timer output clock
	input  wire logic float_bit, // 1 floats the pin
	input  wire logic data_bit,  // 0 forces the pin low
	input  wire logic alt_on,    // Divided oscillator output selected
	input  wire logic alt_clk,   // Divided oscillator clock
	output logic      pin_o,     // Pin output level
	output logic      pin_oe     // Pin output enable
);
	typedef struct packed {
		logic lvl;
		logic oe;
	} pin_s;

	pin_s st_q;
	pin_s st_d;
	logic src;

	// The oscillator output wins, so both clocks never share the pin
	always_comb begin
		if (alt_on) begin
			src = alt_clk;
		end else if (out_en) begin
			src = tclk;
		end else begin
			src = 1'b1;
		end
		st_d     = st_q;
		st_d.lvl = data_bit & src;
		st_d.oe  = ~float_bit;
	end

	// Pin floats until software selects complementary drive
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			st_q <= '{lvl: 1'b1, oe: 1'b0};
		end else begin
			st_q <= st_d;
		end
	end

	assign pin_o  = st_q.lvl;
	assign pin_oe = st_q.oe;
endmodule // timer_pin_driver

// file: hw/dual_timer_output_interrupt_ctrl.sv
// Dual timer control: APB registers, run/stop, flags and pin outputs
`timescale 1ns/1ps
module dual_timer_output_interrupt_ctrl (
	input  wire logic        clk_sys,              // System clock
	input  wire logic        reset,                // Synchronous reset
	input  wire logic        psel,                 // APB select
	input  wire logic        penable,              // APB access phase
	input  wire logic        pwrite,               // APB write
	input  wire logic [17:0] paddr,                // APB byte address
	input  wire logic [31:0] pwdata,               // APB write data
	input  wire logic [3:0]  pstrb,                // APB byte strobes
	output logic      [31:0] prdata,               // APB read data
	output logic             pready,               // APB ready
	output logic             pslverr,              // APB error
	input  wire logic        timer_in_clk_zero,    // Timer zero input clock
	input  wire logic        timer_in_clk_one,     // Timer one input clock
	input  wire logic        sleep_instruction,    // Core is sleeping
	input  wire logic        cpu_mask_low,         // CPU mask level bit 0
	input  wire logic        cpu_mask_high,        // CPU mask level bit 1
	input  wire logic        fast_osc_divided_out, // Fast divided clock
	input  wire logic        fast_div_on,          // Fast clock on pin zero
	input  wire logic        slow_osc_divided_out, // Slow divided clock
	input  wire logic        slow_div_on,          // Slow clock on pin one
	output logic             irq_req_zero,         // Timer zero request
	output logic             irq_req_one,          // Timer one request
	output logic      [1:0]  irq_level_zero,       // Timer zero level
	output logic      [1:0]  irq_level_one,        // Timer one level
	output logic             port_pin_zero,        // Pin zero level
	output logic             port_pin_zero_oe,     // Pin zero enable
	output logic             port_pin_one,         // Pin one level
	output logic             port_pin_one_oe       // Pin one enable
);
	typedef struct packed {
		logic [1:0][1:0] prio;
		logic [1:0]      en_uf;
		logic [1:0]      en_cmp;
		logic [1:0]      fl_uf;
		logic [1:0]      fl_cmp;
		logic            combine_mode;
		logic [1:0]      run_req;
		logic [1:0]      run_act;
		logic [1:0]      out_en;
		logic [1:0]      preset;
		logic [1:0]      float_b;
		logic [1:0]      data_b;
		logic [1:0][7:0] reload;
		logic [1:0][7:0] cmp;
		logic [1:0]      clk_prev;
		logic [1:0]      tout;
		logic [1:0]      irq;
		logic [7:0]      rdata;
	} ctrl_s;

	ctrl_s st_q;
	ctrl_s st_d;

	logic [1:0][7:0] count;
	logic [1:0]      zero;
	logic [1:0]      changed;
	logic [1:0]      next_match;
	logic [1:0]      ch_tick;
	logic [1:0]      ch_load;
	logic [1:0]      fall;
	logic [1:0]      ev_uf;
	logic [1:0]      ev_cmp;
	logic [1:0]      in_clk;
	logic [1:0]      alt_on;
	logic [1:0]      alt_clk;
	logic [1:0]      pin_lvl;
	logic [1:0]      pin_oe;
	logic [1:0]      cpu_mask;
	logic [15:0]     idx;
	logic            hit;
	logic            wr;
	logic            setup;
	logic            combined;

	// Bus decode; the slave never waits
	assign idx      = paddr[17:2];
	assign setup    = psel & ~penable;
	// A refused transfer must leave every register untouched
	assign wr       = psel & penable & pwrite & pstrb[0] & hit;
	assign pready   = 1'b1;
	assign combined = st_q.combine_mode;
	assign cpu_mask = {cpu_mask_high, cpu_mask_low};
	assign in_clk   = {timer_in_clk_one, timer_in_clk_zero};
	assign alt_on   = {slow_div_on, fast_div_on};
	assign alt_clk  = {slow_osc_divided_out, fast_osc_divided_out};

	// Address hit check covers word alignment as well as the index
	always_comb begin
		hit = (paddr[1:0] == 2'h0);
		case (idx)
			dual_timer_pkg::IDX_PRIO,
			dual_timer_pkg::IDX_IRQ_EN,
			dual_timer_pkg::IDX_FLAGS,
			dual_timer_pkg::IDX_CTRL0,
			dual_timer_pkg::IDX_CTRL1,
			dual_timer_pkg::IDX_RELOAD0,
			dual_timer_pkg::IDX_RELOAD1,
			dual_timer_pkg::IDX_CMP0,
			dual_timer_pkg::IDX_CMP1,
			dual_timer_pkg::IDX_COUNT0,
			dual_timer_pkg::IDX_COUNT1,
			dual_timer_pkg::IDX_FLOAT,
			dual_timer_pkg::IDX_PIN_DATA: hit = hit;
			default: hit = 1'b0;
		endcase
	end

	assign pslverr = psel & penable & ~hit;

	// Falling edges of the input clocks; sleep freezes counting only
	assign fall = st_q.clk_prev & ~in_clk;

	// Counting uses the old run state, giving one more count on stop
	always_comb begin
		ch_tick[0] = fall[0] & st_q.run_act[0] & ~sleep_instruction;
		if (combined) begin
			ch_tick[1] = ch_tick[0] & zero[0];
		end else begin
			ch_tick[1] = fall[1] & st_q.run_act[1] & ~sleep_instruction;
		end
	end

	// Underflow, reload and compare events for both modes
	always_comb begin
		if (combined) begin
			ev_uf[0]   = ch_tick[0] & zero[0] & zero[1];
			ev_uf[1]   = ev_uf[0];
			ch_load[0] = st_q.preset[0] | ev_uf[0];
			ch_load[1] = st_q.preset[0] | ev_uf[0];
			ev_cmp[0]  = (changed[0] | changed[1]) & (&next_match);
			ev_cmp[1]  = ev_cmp[0];
		end else begin
			ev_uf      = ch_tick & zero;
			ch_load    = st_q.preset | ev_uf;
			ev_cmp     = changed & next_match;
		end
	end

	// Counter channels; combined mode chains the borrow into timer one
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_chan
			timer_count_channel u_chan (
				.clk_sys    (clk_sys),
				.reset      (reset),
				.tick       (ch_tick[gi]),
				.load       (ch_load[gi]),
				.reload_val (st_q.reload[gi]),
				.cmp_val    (st_q.cmp[gi]),
				.count      (count[gi]),
				.zero       (zero[gi]),
				.changed    (changed[gi]),
				.next_match (next_match[gi])
			);

			timer_pin_driver u_pin (
				.clk_sys   (clk_sys),
				.reset     (reset),
				.out_en    (st_q.out_en[gi]),
				.tclk      (st_q.tout[gi]),
				.float_bit (st_q.float_b[gi]),
				.data_bit  (st_q.data_b[gi]),
				.alt_on    (alt_on[gi]),
				.alt_clk   (alt_clk[gi]),
				.pin_o     (pin_lvl[gi]),
				.pin_oe    (pin_oe[gi])
			);
		end
	endgenerate

	assign port_pin_zero    = pin_lvl[0];
	assign port_pin_zero_oe = pin_oe[0];
	assign port_pin_one     = pin_lvl[1];
	assign port_pin_one_oe  = pin_oe[1];

	// Next state of all control registers
	always_comb begin
		st_d          = st_q;
		st_d.clk_prev = in_clk;
		st_d.preset   = 2'h0;

		// Run state follows the request at an input clock fall; combined mode stops timer one at once
		for (int k = 0; k < 2; k++) begin
			if (fall[k]) begin
				st_d.run_act[k] = st_q.run_req[k];
			end
		end
		if (combined) begin
			st_d.run_act[1] = 1'b0;
		end

		// Output clock: a load other than the channel's own preset raises it, a compare match drops it
		for (int k = 0; k < 2; k++) begin
			if (ch_load[k] & ~st_q.preset[k]) begin
				st_d.tout[k] = 1'b1;
			end else if (ev_cmp[k]) begin
				st_d.tout[k] = 1'b0;
			end
		end

		// Register writes
		if (wr) begin
			case (idx)
				dual_timer_pkg::IDX_PRIO: begin
					st_d.prio[0] = pwdata[dual_timer_pkg::PRIO_ZERO_LSB +: 2];
					st_d.prio[1] = pwdata[dual_timer_pkg::PRIO_ONE_LSB +: 2];
				end
				dual_timer_pkg::IDX_IRQ_EN: begin
					st_d.en_uf[0]  = pwdata[dual_timer_pkg::BIT_UF_ZERO];
					st_d.en_uf[1]  = pwdata[dual_timer_pkg::BIT_UF_ONE];
					st_d.en_cmp[0] = pwdata[dual_timer_pkg::BIT_CMP_ZERO];
					st_d.en_cmp[1] = pwdata[dual_timer_pkg::BIT_CMP_ONE];
				end
				dual_timer_pkg::IDX_FLAGS: begin
					if (pwdata[dual_timer_pkg::BIT_UF_ZERO]) begin
						st_d.fl_uf[0] = 1'b0;
					end
					if (pwdata[dual_timer_pkg::BIT_UF_ONE]) begin
						st_d.fl_uf[1] = 1'b0;
					end
					if (pwdata[dual_timer_pkg::BIT_CMP_ZERO]) begin
						st_d.fl_cmp[0] = 1'b0;
					end
					if (pwdata[dual_timer_pkg::BIT_CMP_ONE]) begin
						st_d.fl_cmp[1] = 1'b0;
					end
				end
				dual_timer_pkg::IDX_CTRL0: begin
					st_d.combine_mode = pwdata[dual_timer_pkg::BIT_COMBINE];
					st_d.run_req[0]   = pwdata[dual_timer_pkg::BIT_RUN];
					st_d.out_en[0]    = pwdata[dual_timer_pkg::BIT_OUT_EN];
					st_d.preset[0]    = pwdata[dual_timer_pkg::BIT_PRESET];
				end
				dual_timer_pkg::IDX_CTRL1: begin
					st_d.run_req[1] = pwdata[dual_timer_pkg::BIT_RUN];
					st_d.out_en[1]  = pwdata[dual_timer_pkg::BIT_OUT_EN];
					st_d.preset[1]  = pwdata[dual_timer_pkg::BIT_PRESET] & ~combined;
				end
				dual_timer_pkg::IDX_RELOAD0: st_d.reload[0] = pwdata[7:0];
				dual_timer_pkg::IDX_RELOAD1: st_d.reload[1] = pwdata[7:0];
				dual_timer_pkg::IDX_CMP0:    st_d.cmp[0]    = pwdata[7:0];
				dual_timer_pkg::IDX_CMP1:    st_d.cmp[1]    = pwdata[7:0];
				dual_timer_pkg::IDX_FLOAT:   st_d.float_b   = pwdata[1:0];
				dual_timer_pkg::IDX_PIN_DATA: st_d.data_b   = pwdata[1:0];
				default: st_d.rdata = st_q.rdata;
			endcase
		end

		// Combined mode pins timer one's run request at zero
		if (st_d.combine_mode) begin
			st_d.run_req[1] = 1'b0;
		end

		// Events set flags after the clear so a simultaneous set survives
		if (ev_uf[0] & ~combined) begin
			st_d.fl_uf[0] = 1'b1;
		end
		if (ev_cmp[0] & ~combined) begin
			st_d.fl_cmp[0] = 1'b1;
		end
		if (ev_uf[1]) begin
			st_d.fl_uf[1] = 1'b1;
		end
		if (ev_cmp[1]) begin
			st_d.fl_cmp[1] = 1'b1;
		end

		// Requests compare each priority with the core's mask level
		st_d.irq[0] = ~combined
			& ((st_q.fl_uf[0] & st_q.en_uf[0])
			| (st_q.fl_cmp[0] & st_q.en_cmp[0]))
			& (st_q.prio[0] > cpu_mask);
		st_d.irq[1] = ((st_q.fl_uf[1] & st_q.en_uf[1])
			| (st_q.fl_cmp[1] & st_q.en_cmp[1]))
			& (st_q.prio[1] > cpu_mask);

		// Read data is captured in the setup cycle for the access phase
		if (setup) begin
			st_d.rdata = 8'h00;
			case (idx)
				dual_timer_pkg::IDX_PRIO:
					st_d.rdata = {4'h0, st_q.prio[1], st_q.prio[0]};
				dual_timer_pkg::IDX_IRQ_EN:
					st_d.rdata = {1'b0, st_q.en_cmp[1], st_q.en_uf[1],
						st_q.en_cmp[0], st_q.en_uf[0], 3'h0};
				dual_timer_pkg::IDX_FLAGS:
					st_d.rdata = {1'b0, st_q.fl_cmp[1], st_q.fl_uf[1],
						st_q.fl_cmp[0], st_q.fl_uf[0], 3'h0};
				dual_timer_pkg::IDX_CTRL0:
					st_d.rdata = {st_q.combine_mode, 3'h0, st_q.out_en[0],
						st_q.run_req[0] | st_q.run_act[0], 2'h0};
				dual_timer_pkg::IDX_CTRL1:
					st_d.rdata = {4'h0, st_q.out_en[1],
						st_q.run_req[1] | st_q.run_act[1], 2'h0};
				dual_timer_pkg::IDX_RELOAD0: st_d.rdata = st_q.reload[0];
				dual_timer_pkg::IDX_RELOAD1: st_d.rdata = st_q.reload[1];
				dual_timer_pkg::IDX_CMP0:    st_d.rdata = st_q.cmp[0];
				dual_timer_pkg::IDX_CMP1:    st_d.rdata = st_q.cmp[1];
				// Each byte reads live; no shadow copy of the high byte
				dual_timer_pkg::IDX_COUNT0:  st_d.rdata = count[0];
				dual_timer_pkg::IDX_COUNT1:  st_d.rdata = count[1];
				dual_timer_pkg::IDX_FLOAT:
					st_d.rdata = {6'h00, st_q.float_b};
				dual_timer_pkg::IDX_PIN_DATA:
					st_d.rdata = {6'h00, st_q.data_b};
				default: st_d.rdata = 8'h00;
			endcase
		end
	end

	// Reset leaves timers stopped, outputs off and pins floating
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			st_q         <= '0;
			st_q.prio    <= {dual_timer_pkg::RST_PRIO,
				dual_timer_pkg::RST_PRIO};
			st_q.float_b <= dual_timer_pkg::RST_FLOAT;
			st_q.data_b  <= dual_timer_pkg::RST_DATA;
			st_q.reload  <= {dual_timer_pkg::RST_RELOAD,
				dual_timer_pkg::RST_RELOAD};
			st_q.cmp     <= {dual_timer_pkg::RST_CMP,
				dual_timer_pkg::RST_CMP};
			st_q.run_req <= 2'h0;
			st_q.out_en  <= 2'h0;
		end else begin
			st_q <= st_d;
		end
	end

	assign prdata         = {24'h000000, st_q.rdata};
	assign irq_req_zero   = st_q.irq[0];
	assign irq_req_one    = st_q.irq[1];
	assign irq_level_zero = st_q.prio[0];
	assign irq_level_one  = st_q.prio[1];
endmodule // dual_timer_output_interrupt_ctrl

// file: verif/dual_timer_output_interrupt_ctrl_assertions.sv
// Concurrent checks on the ports of the dual timer block
`timescale 1ns/1ps
module dual_timer_checker (
	input wire logic        clk_sys,        // System clock
	input wire logic        reset,          // Synchronous reset
	input wire logic        psel,           // APB select
	input wire logic        penable,        // APB access phase
	input wire logic        pwrite,         // APB write
	input wire logic [17:0] paddr,          // APB byte address
	input wire logic [31:0] pwdata,         // APB write data
	input wire logic [3:0]  pstrb,          // APB strobes
	input wire logic [31:0] prdata,         // APB read data
	input wire logic        pready,         // APB ready
	input wire logic        pslverr,        // APB error
	input wire logic        cpu_mask_low,   // Mask bit 0
	input wire logic        cpu_mask_high,  // Mask bit 1
	input wire logic        irq_req_zero,   // Request zero
	input wire logic        irq_req_one,    // Request one
	input wire logic [1:0]  irq_level_zero, // Level zero
	input wire logic [1:0]  irq_level_one   // Level one
);
	// One clock domain, so one clocking and one reset for all
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	// Priority write and the core mask as plain helper nets
	logic       wr_prio;
	logic [1:0] mask;
	assign wr_prio = psel && penable && pwrite && pstrb[0]
		&& paddr == {dual_timer_pkg::IDX_PRIO, 2'h0};
	assign mask = {cpu_mask_high, cpu_mask_low};

	a_ready_always: assert property (pready)
		else $error("pready low");
	a_rdata_upper: assert property (prdata[31:8] == 24'h0)
		else $error("prdata upper bits set");
	a_err_in_access: assert property (pslverr |-> psel && penable)
		else $error("pslverr outside access");
	a_err_misaligned: assert property (
		psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
		else $error("misaligned access without error");
	a_err_mapped: assert property (psel && penable
		&& paddr == {dual_timer_pkg::IDX_FLAGS, 2'h0} |-> !pslverr)
		else $error("mapped access flagged");
	a_rdata_hold: assert property (!(psel && !penable) |=> $stable(prdata))
		else $error("prdata moved outside setup");
	a_prio_level: assert property (
		wr_prio |=> irq_level_zero == $past(pwdata[1:0])
		&& irq_level_one == $past(pwdata[3:2]))
		else $error("priority level not taken");
	a_req_zero_mask: assert property (
		irq_req_zero |-> $past(irq_level_zero) > $past(mask))
		else $error("request zero not above mask");
	a_req_one_mask: assert property (
		irq_req_one |-> $past(irq_level_one) > $past(mask))
		else $error("request one not above mask");
endmodule // dual_timer_checker

bind dual_timer_output_interrupt_ctrl dual_timer_checker i_dual_timer_checker (
	.clk_sys, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
	.prdata, .pready, .pslverr, .cpu_mask_low, .cpu_mask_high,
	.irq_req_zero, .irq_req_one, .irq_level_zero, .irq_level_one);

// file: verif/core_pin_model.sv
// Core and pin side model: mask level source and pin wire levels
`timescale 1ns/1ps
module core_pin_model (
	input  wire logic       clk_sys,       // System clock
	input  wire logic [1:0] mask_level,    // Mask level asked by bench
	input  wire logic       pin_zero,      // Pin zero driven level
	input  wire logic       pin_zero_oe,   // Pin zero enable
	input  wire logic       pin_one,       // Pin one driven level
	input  wire logic       pin_one_oe,    // Pin one enable
	output logic            cpu_mask_low,  // Core mask bit 0
	output logic            cpu_mask_high, // Core mask bit 1
	output logic            wire_zero,     // Level seen on pin zero
	output logic            wire_one       // Level seen on pin one
);
	logic last_zero_q = 1'b0;
	logic last_one_q  = 1'b0;

	// Core mask level as two loose bits
	assign cpu_mask_low  = mask_level[0];
	assign cpu_mask_high = mask_level[1];

	// Floating pin has no pull, so show noise rather than the last level
	assign wire_zero = pin_zero_oe ? pin_zero : ~last_zero_q;
	assign wire_one  = pin_one_oe ? pin_one : ~last_one_q;

	// Remember the wire so a floating pin keeps changing
	always @(posedge clk_sys) begin
		last_zero_q <= wire_zero;
		last_one_q  <= wire_one;
	end
endmodule // core_pin_model

// file: verif/test_dual_timer_output_interrupt_ctrl.sv
// Self-checking bench for the dual timer block over APB
`timescale 1ns/1ps
module test_dual_timer_output_interrupt_ctrl;
	logic        clk_sys, reset, psel, penable, pwrite, pready, pslverr;
	logic        tin0, tin1, sleep_on, fclk, sclk, fon, son, mlo, mhi;
	logic        irq0, irq1, p0, p0e, p1, p1e, w0, w1, err_q;
	logic [17:0] paddr;
	logic [31:0] pwdata, prdata, rd_q;
	logic [1:0]  lvl0, lvl1, mask;
	logic [15:0] ri [10];
	logic [7:0]  rv [10];
	int          error_cnt, n_checks, lo [2], hi [2];

	dual_timer_output_interrupt_ctrl i_dual_timer_output_interrupt_ctrl (
		.clk_sys, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb(4'h1), .prdata, .pready, .pslverr,
		.timer_in_clk_zero(tin0), .timer_in_clk_one(tin1),
		.sleep_instruction(sleep_on), .cpu_mask_low(mlo),
		.cpu_mask_high(mhi), .fast_osc_divided_out(fclk), .fast_div_on(fon),
		.slow_osc_divided_out(sclk), .slow_div_on(son),
		.irq_req_zero(irq0), .irq_req_one(irq1), .irq_level_zero(lvl0),
		.irq_level_one(lvl1), .port_pin_zero(p0), .port_pin_zero_oe(p0e),
		.port_pin_one(p1), .port_pin_one_oe(p1e));

	core_pin_model i_core_pin_model (
		.clk_sys, .mask_level(mask), .pin_zero(p0), .pin_zero_oe(p0e),
		.pin_one(p1), .pin_one_oe(p1e), .cpu_mask_low(mlo),
		.cpu_mask_high(mhi), .wire_zero(w0), .wire_one(w1));

	// Clock at 20 MHz
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	// Divided oscillator stand-ins and pin level counters
	always @(posedge clk_sys) begin
		fclk <= ~fclk;
		sclk <= ~sclk;
		if (p0e) begin
			if (w0 === 1'b0) lo[0]++;
			if (w0 === 1'b1) hi[0]++;
		end
		if (p1e) begin
			if (w1 === 1'b0) lo[1]++;
			if (w1 === 1'b1) hi[1]++;
		end
	end

	// A hang counts as a mismatch and closes the run
	initial begin
		repeat (20000) @(posedge clk_sys);
		error_cnt++;
		tally_and_finish();
	end

	task tally_and_finish;
		$display("Checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task chk(input logic [31:0] g, input logic [31:0] e, input string m);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("Error at %0t: %s got %h exp %h", $time, m, g, e);
		end
	endtask

	task cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	// One APB transfer; the edge after release keeps transfers apart
	task apb(input logic w, input logic [15:0] i, input logic [7:0] d,
		input logic [1:0] ofs = 2'h0);
		int k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {i, ofs};
		pwdata <= {24'h0, d};
		@(posedge clk_sys);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk_sys);
			k++;
		end while (pready !== 1'b1 && k < 16);
		if (k >= 16) begin
			error_cnt++;
			tally_and_finish();
		end
		rd_q = prdata;
		err_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask

	task wr(input logic [15:0] i, input logic [7:0] d);
		apb(1'b1, i, d);
	endtask

	task rd(input logic [15:0] i, input logic [7:0] e);
		apb(1'b0, i, 8'h00);
		chk(rd_q, {24'h0, e}, "register read");
	endtask

	// Timer input clock: a fall is the count edge
	task tick(input int n);
		repeat (n) begin
			tin0 <= 1'b1;
			tin1 <= 1'b1;
			cyc(2);
			tin0 <= 1'b0;
			tin1 <= 1'b0;
			cyc(2);
		end
	endtask

	initial begin
		logic [7:0]  c, e, fb;
		logic [15:0] o;
		{psel, penable, pwrite, tin0, tin1, sleep_on, fon, son} = '0;
		{fclk, sclk, paddr, pwdata, mask, reset} = '1;
		{fclk, paddr, pwdata, mask} = '0;
		ri = '{dual_timer_pkg::IDX_PRIO, dual_timer_pkg::IDX_IRQ_EN,
			dual_timer_pkg::IDX_FLAGS, dual_timer_pkg::IDX_CTRL0,
			dual_timer_pkg::IDX_CTRL1, dual_timer_pkg::IDX_FLOAT,
			dual_timer_pkg::IDX_PIN_DATA, dual_timer_pkg::IDX_RELOAD0,
			dual_timer_pkg::IDX_CMP1, dual_timer_pkg::IDX_COUNT1};
		rv = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h03, 8'hff, 8'h00,
			8'hff};
		cyc(8);
		reset <= 1'b0;
		cyc(1);
		chk(p0e | p1e, 1'b0, "pins float after reset");
		foreach (ri[i]) rd(ri[i], rv[i]);
		apb(1'b0, 16'hff21, 8'h00);
		chk(err_q, 1'b1, "unmapped error");
		// Misaligned write is refused and must not land
		apb(1'b1, dual_timer_pkg::IDX_PRIO, 8'h03, 2'h1);
		chk(err_q, 1'b1, "misaligned error");
		rd(dual_timer_pkg::IDX_PRIO, 8'h00);
		wr(dual_timer_pkg::IDX_COUNT0, 8'h12);
		rd(dual_timer_pkg::IDX_COUNT0, 8'hff);
		wr(dual_timer_pkg::IDX_PRIO, 8'h0b);
		rd(dual_timer_pkg::IDX_PRIO, 8'h0b);
		wr(dual_timer_pkg::IDX_PRIO, 8'h00);
		$display("Test registers done");
		for (int t = 0; t < 2; t++) begin
			o = t[15:0];
			fb = 8'h18 << (2 * t);
			wr(dual_timer_pkg::IDX_FLOAT, 8'h00);
			wr(dual_timer_pkg::IDX_PIN_DATA, 8'h03);
			wr(dual_timer_pkg::IDX_RELOAD0 + o, 8'h02);
			wr(dual_timer_pkg::IDX_CMP0 + o, 8'h01);
			wr(dual_timer_pkg::IDX_CTRL0 + o, 8'h02);
			wr(dual_timer_pkg::IDX_CTRL0 + o, 8'h0c);
			lo = '{0, 0};
			hi = '{0, 0};
			tick(8);
			rd(dual_timer_pkg::IDX_FLAGS, fb);
			chk(lo[t] > 0 && hi[t] > 0, 1'b1, "clock on pin");
			wr(dual_timer_pkg::IDX_IRQ_EN, fb);
			wr(dual_timer_pkg::IDX_PRIO, 8'h02 << (2 * t));
			mask <= 2'h1;
			cyc(3);
			chk(t ? irq1 : irq0, 1'b1, "request raised");
			mask <= 2'h2;
			cyc(3);
			chk(t ? irq1 : irq0, 1'b0, "request masked");
			mask <= 2'h1;
			wr(dual_timer_pkg::IDX_FLAGS, 8'h00);
			cyc(3);
			chk(t ? irq1 : irq0, 1'b1, "zero write kept flag");
			wr(dual_timer_pkg::IDX_IRQ_EN, 8'h00);
			cyc(3);
			chk(t ? irq1 : irq0, 1'b0, "request disabled");
			wr(dual_timer_pkg::IDX_FLAGS, fb);
			rd(dual_timer_pkg::IDX_FLAGS, 8'h00);
			wr(dual_timer_pkg::IDX_CTRL0 + o, 8'h08);
			rd(dual_timer_pkg::IDX_CTRL0 + o, 8'h0c);
			apb(1'b0, dual_timer_pkg::IDX_COUNT0 + o, 8'h00);
			c = rd_q[7:0];
			e = (c == 8'h00) ? 8'h02 : c - 8'h01;
			tick(1);
			rd(dual_timer_pkg::IDX_COUNT0 + o, e);
			tick(2);
			rd(dual_timer_pkg::IDX_COUNT0 + o, e);
			rd(dual_timer_pkg::IDX_CTRL0 + o, 8'h08);
			wr(dual_timer_pkg::IDX_CTRL0 + o, 8'h00);
			cyc(2);
			chk(t ? {p1, p1e} : {p0, p0e}, 2'h3, "pin held high");
			wr(dual_timer_pkg::IDX_PIN_DATA, t ? 8'h01 : 8'h02);
			cyc(2);
			chk(t ? p1 : p0, 1'b0, "data bit forces low");
			wr(dual_timer_pkg::IDX_FLOAT, t ? 8'h02 : 8'h01);
			cyc(2);
			chk(t ? p1e : p0e, 1'b0, "float bit floats pin");
			wr(dual_timer_pkg::IDX_PRIO, 8'h00);
			mask <= 2'h0;
			$display("Test timer %0d done", t);
		end
		wr(dual_timer_pkg::IDX_FLOAT, 8'h00);
		wr(dual_timer_pkg::IDX_PIN_DATA, 8'h03);
		wr(dual_timer_pkg::IDX_CTRL0, 8'h08);
		wr(dual_timer_pkg::IDX_CTRL1, 8'h08);
		fon <= 1'b1;
		son <= 1'b1;
		lo = '{0, 0};
		hi = '{0, 0};
		cyc(8);
		chk(lo[0] > 0 && hi[0] > 0, 1'b1, "fast clock wins");
		chk(lo[1] > 0 && hi[1] > 0, 1'b1, "slow clock wins");
		fon <= 1'b0;
		son <= 1'b0;
		wr(dual_timer_pkg::IDX_RELOAD0, 8'h80);
		wr(dual_timer_pkg::IDX_CMP0, 8'h7f);
		wr(dual_timer_pkg::IDX_CTRL0, 8'h02);
		wr(dual_timer_pkg::IDX_CTRL0, 8'h04);
		tick(1);
		sleep_on <= 1'b1;
		apb(1'b0, dual_timer_pkg::IDX_COUNT0, 8'h00);
		c = rd_q[7:0];
		tick(3);
		rd(dual_timer_pkg::IDX_COUNT0, c);
		sleep_on <= 1'b0;
		tick(2);
		apb(1'b0, dual_timer_pkg::IDX_COUNT0, 8'h00);
		chk(rd_q[7:0] < c, 1'b1, "count resumes");
		wr(dual_timer_pkg::IDX_CTRL0, 8'h00);
		tick(1);
		$display("Test sleep done");
		// Timer zero compare flag stays set: combined mode must gate its request
		wr(dual_timer_pkg::IDX_FLAGS, 8'h68);
		wr(dual_timer_pkg::IDX_CMP0, 8'h00);
		wr(dual_timer_pkg::IDX_CMP1, 8'h00);
		wr(dual_timer_pkg::IDX_IRQ_EN, 8'h78);
		wr(dual_timer_pkg::IDX_PRIO, 8'h0f);
		wr(dual_timer_pkg::IDX_RELOAD0, 8'h01);
		wr(dual_timer_pkg::IDX_RELOAD1, 8'h00);
		wr(dual_timer_pkg::IDX_CTRL0, 8'h82);
		rd(dual_timer_pkg::IDX_CTRL0, 8'h80);
		wr(dual_timer_pkg::IDX_CTRL0, 8'h84);
		tick(6);
		wr(dual_timer_pkg::IDX_CTRL0, 8'h80);
		tick(2);
		rd(dual_timer_pkg::IDX_COUNT1, 8'h00);
		apb(1'b0, dual_timer_pkg::IDX_FLAGS, 8'h00);
		chk(rd_q & 32'h78, 32'h70, "combined flags");
		cyc(2);
		chk({irq0, irq1}, 2'h1, "combined requests");
		$display("Test combined done");
		tally_and_finish();
	end
endmodule // test_dual_timer_output_interrupt_ctrl
